/* rtl/abrmon_defines.svh */
`ifndef ABRMON_DEFINES_SVH
`define ABRMON_DEFINES_SVH

// Counter and constant widths.
`define ABRMON_CNT_W      24
`define ABRMON_RATE_W     16
`define ABRMON_FRAC_W     8
// Default interval length in cell slots and the derived Trm count.
`define ABRMON_INTERVAL   32'd1000000
`define ABRMON_NRM        32
`define ABRMON_MRM        2
`define ABRMON_TRM_SLOTS  32'd12500
// Tolerance constants; multipliers are fixed point with ABRMON_FRAC_W fraction bits.
`define ABRMON_A          8
`define ABRMON_B          16'h0120
`define ABRMON_C          16'h00E0
`define ABRMON_D          8
`define ABRMON_E          8
`define ABRMON_F          16'h0120
`define ABRMON_G          16'h00E0
`define ABRMON_H          8
`define ABRMON_U          8
`define ABRMON_V          16'h0010
`define ABRMON_SWITCHES   2
// Flag bit positions.
`define ABRMON_FLG_FLO    0
`define ABRMON_FLG_FHI    1
`define ABRMON_FLG_BLO    2
`define ABRMON_FLG_BHI    3
`define ABRMON_FLG_VIOL   4

`endif

/* rtl/abrmon_pkg.sv */
`include "abrmon_defines.svh"

package abrmon_pkg;
    typedef logic [`ABRMON_CNT_W-1:0] abrmon_cnt_t;
    typedef logic [4:0]               abrmon_flags_t;

    typedef enum logic [1:0] {
        ABRMON_RUN   = 2'b01,
        ABRMON_CHECK = 2'b10
    } abrmon_phase_e;

    typedef struct packed {
        abrmon_cnt_t r_all0;
        abrmon_cnt_t r_frm0;
        abrmon_cnt_t r_frm1;
        abrmon_cnt_t r_brm0;
        abrmon_cnt_t t_frm0;
        abrmon_cnt_t t_frm1;
        abrmon_cnt_t r_viol;
    } abrmon_counts_s;
endpackage : abrmon_pkg

/* rtl/abrmon_cnt_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Carries the interval counts from the main block to the bound checker.
interface abrmon_cnt_if;
    import abrmon_pkg::*;
    abrmon_counts_s cnt;
    logic [31:0]    len;
    abrmon_flags_t  flags;

    modport src (output cnt, output len, input flags);
    modport chk (input cnt, input len, output flags);
endinterface : abrmon_cnt_if

`default_nettype wire

/* rtl/abrmon_check.sv */
`timescale 1ns/1ps
`default_nettype none

`include "abrmon_defines.svh"

// Combinational evaluation of the five count bounds at interval end.
module abrmon_check
    import abrmon_pkg::*;
#(
    parameter int NRM      = `ABRMON_NRM,
    parameter int MRM      = `ABRMON_MRM,
    parameter int TRM      = `ABRMON_TRM_SLOTS,
    parameter int SWITCHES = `ABRMON_SWITCHES
) (
    abrmon_cnt_if.chk bus
);
    localparam int FW = `ABRMON_FRAC_W;

    // Fixed-point scaling by a tolerance multiplier; wide to avoid overflow.
    function automatic logic [63:0] scale(input logic [39:0] x, input logic [15:0] k);
        logic [63:0] p;
        p = 64'({x, 24'h0} >> 24) * 64'(k);
        return p >> FW;
    endfunction : scale

    function automatic logic [39:0] max40(input logic [39:0] x, input logic [39:0] y);
        return (x > y) ? x : y;
    endfunction : max40

    function automatic logic [39:0] min40(input logic [39:0] x, input logic [39:0] y);
        return (x < y) ? x : y;
    endfunction : min40

    logic [39:0] per_nrm, per_mrm, per_trm, fwd_hi, fwd_lo, tot_frm, bwd_base, bwd_hi, bwd_lo;
    logic [39:0] viol_hi;

    always_comb begin
        per_nrm  = 40'(bus.cnt.r_all0) / 40'(NRM);
        per_mrm  = 40'(bus.cnt.r_all0) / 40'(MRM + 1);
        per_trm  = 40'(bus.len) / 40'(TRM);
        // Count shifted up by d rather than the lower bound, so the comparison stays unsigned.
        fwd_lo   = 40'(scale(per_nrm, `ABRMON_C));
        fwd_hi   = max40(40'(`ABRMON_A),
                         40'(scale(min40(per_nrm + per_trm, per_mrm), `ABRMON_B)));
        tot_frm  = 40'(bus.cnt.t_frm0) + 40'(bus.cnt.t_frm1);
        // Ten per unit length per hop, with length in Trm units here.
        bwd_base = tot_frm + 40'(10) * per_trm * 40'(SWITCHES + 1);
        bwd_hi   = max40(40'(`ABRMON_E), 40'(scale(bwd_base, `ABRMON_F)));
        bwd_lo   = 40'(scale(min40(40'(bus.cnt.t_frm0), 40'(bus.cnt.r_frm0)), `ABRMON_G));
        viol_hi  = max40(40'(`ABRMON_U),
                         40'(scale(40'(bus.cnt.r_frm0) + 40'(bus.cnt.r_frm1), `ABRMON_V)));
        bus.flags = '0;
        bus.flags[`ABRMON_FLG_FLO]  = (40'(bus.cnt.r_frm0) + 40'(`ABRMON_D)) < fwd_lo;
        bus.flags[`ABRMON_FLG_FHI]  = 40'(bus.cnt.r_frm0) > fwd_hi;
        bus.flags[`ABRMON_FLG_BLO]  = (40'(bus.cnt.r_brm0) + 40'(`ABRMON_H)) < bwd_lo;
        bus.flags[`ABRMON_FLG_BHI]  = 40'(bus.cnt.r_brm0) > bwd_hi;
        bus.flags[`ABRMON_FLG_VIOL] = 40'(bus.cnt.r_viol) > viol_hi;
    end
endmodule : abrmon_check

`default_nettype wire

/* rtl/abrmon_top.sv */
`timescale 1ns/1ps
`default_nettype none

`include "abrmon_defines.svh"

// Contract
// - Check forward RM count within bounds
// - Tolerances b above one, c below
// - Backward count above g*min minus h
// - Backward count below max(e, f*sum)
// - S is switch count on path
// - Tolerances f above one, g below
// - Count RM cells with field violations
// - Violations below max(u, v*total)
// - Increment is reciprocal of PACR
module abrmon_top
    import abrmon_pkg::*;
#(
    parameter int          RATE_W   = `ABRMON_RATE_W,
    parameter logic [31:0] INTERVAL = `ABRMON_INTERVAL,
    parameter int          NRM      = `ABRMON_NRM,
    parameter int          MRM      = `ABRMON_MRM,
    parameter int          TRM      = `ABRMON_TRM_SLOTS,
    parameter int          SWITCHES = `ABRMON_SWITCHES
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    input  wire logic              CE,
    input  wire logic              FWD_VALID,
    input  wire logic              FWD_CLP,
    input  wire logic              FWD_RM,
    input  wire logic [RATE_W-1:0] FWD_CCR,
    input  wire logic [RATE_W-1:0] FWD_MCR,
    input  wire logic [RATE_W-1:0] PACR,
    input  wire logic [RATE_W-1:0] NEG_MCR,
    input  wire logic              BWD_RX_RM,
    input  wire logic              BWD_RX_CLP,
    input  wire logic              BWD_TX_RM,
    input  wire logic              BWD_TX_CLP,
    output logic                   INTERVAL_END,
    output logic [4:0]             BOUND_FLAGS,
    output logic                   NONCONFORM,
    output logic [`ABRMON_CNT_W-1:0] VIOL_COUNT
);
    typedef struct packed {
        abrmon_phase_e  phase;
        logic [31:0]    slot;
        abrmon_counts_s cnt;
        logic           end_q;
        abrmon_flags_t  flags;
        logic           flag_any;
        abrmon_cnt_t    viol_last;
    } abrmon_state_s;

    abrmon_state_s st_q, st_d;
    abrmon_cnt_if  cif ();

    // Saturating increment keeps a runaway source from wrapping a count to small.
    function automatic abrmon_cnt_t inc(input abrmon_cnt_t v, input logic en);
        return (en && (v != '1)) ? v + 1'b1 : v;
    endfunction : inc

    logic fwd_rm0, fwd_rm1, field_bad;

    assign cif.cnt = st_q.cnt;
    assign cif.len = INTERVAL;

    abrmon_check #(
        .NRM      (NRM),
        .MRM      (MRM),
        .TRM      (TRM),
        .SWITCHES (SWITCHES)
    ) u_check (
        .bus (cif.chk)
    );

    always_comb begin
        fwd_rm0   = FWD_VALID && FWD_RM && !FWD_CLP;
        fwd_rm1   = FWD_VALID && FWD_RM && FWD_CLP;
        // The increment is 1/PACR, so CCR above 1/I is CCR above PACR.
        field_bad = FWD_VALID && FWD_RM && ((FWD_CCR > PACR) || (FWD_MCR > NEG_MCR));
        st_d       = st_q;
        st_d.end_q = 1'b0;
        unique case (st_q.phase)
            ABRMON_RUN: begin
                st_d.cnt.r_all0 = inc(st_q.cnt.r_all0, FWD_VALID && !FWD_CLP);
                st_d.cnt.r_frm0 = inc(st_q.cnt.r_frm0, fwd_rm0);
                st_d.cnt.r_frm1 = inc(st_q.cnt.r_frm1, fwd_rm1);
                st_d.cnt.r_brm0 = inc(st_q.cnt.r_brm0, BWD_RX_RM && !BWD_RX_CLP);
                st_d.cnt.t_frm0 = inc(st_q.cnt.t_frm0, BWD_TX_RM && !BWD_TX_CLP);
                st_d.cnt.t_frm1 = inc(st_q.cnt.t_frm1, BWD_TX_RM && BWD_TX_CLP);
                st_d.cnt.r_viol = inc(st_q.cnt.r_viol, field_bad);
                if (st_q.slot == INTERVAL - 32'd1) begin
                    st_d.phase = ABRMON_CHECK;
                end else begin
                    st_d.slot = st_q.slot + 32'd1;
                end
            end
            ABRMON_CHECK: begin
                // One slot spent judging; cells in it are not counted by design.
                st_d.flags     = cif.flags;
                st_d.flag_any  = |cif.flags;
                st_d.viol_last = st_q.cnt.r_viol;
                st_d.end_q     = 1'b1;
                st_d.cnt       = '0;
                st_d.slot      = '0;
                st_d.phase     = ABRMON_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_q       <= '0;
            st_q.phase <= ABRMON_RUN;
        end else if (CE) begin
            st_q <= st_d;
        end
    end

    assign INTERVAL_END = st_q.end_q;
    assign BOUND_FLAGS  = st_q.flags;
    assign NONCONFORM   = st_q.flag_any;
    assign VIOL_COUNT   = st_q.viol_last;
endmodule : abrmon_top

`default_nettype wire

/* tb/abrmon_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module abrmon_top_props
    import abrmon_pkg::*;
#(
    parameter logic [31:0] INTERVAL = 32'd100
) (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        CE,
    input wire logic        INTERVAL_END,
    input wire logic [4:0]  BOUND_FLAGS,
    input wire logic        NONCONFORM,
    input wire abrmon_cnt_t VIOL_COUNT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Enabled edges since the last judgement; the window allows for the check cycle.
    logic [31:0] gap_q;
    always_ff @(posedge CLK_SYS) begin
        if (RST || INTERVAL_END) gap_q <= 32'h0;
        else if (CE) gap_q <= gap_q + 32'h1;
    end
    sequence s_end; INTERVAL_END ##1 !INTERVAL_END; endsequence
    property p_end_pulse; INTERVAL_END |-> s_end; endproperty
    property p_cadence; INTERVAL_END |-> gap_q >= INTERVAL - 1 && gap_q <= INTERVAL + 2;
    endproperty
    property p_flags_hold; !INTERVAL_END |-> $stable(BOUND_FLAGS); endproperty
    property p_nc_or; NONCONFORM == |BOUND_FLAGS; endproperty
    property p_nc_fall; $fell(NONCONFORM) |-> INTERVAL_END; endproperty
    property p_viol_hold; !INTERVAL_END |-> $stable(VIOL_COUNT); endproperty
    property p_viol_floor; INTERVAL_END && VIOL_COUNT <= 8 |-> !BOUND_FLAGS[4]; endproperty
    property p_freeze; !CE |=> $stable(INTERVAL_END) && $stable(VIOL_COUNT); endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("end pulse too long");
    a_cadence: assert property (p_cadence) else $error("interval length wrong");
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
    a_nc_or: assert property (p_nc_or) else $error("nonconform not flag or");
    a_nc_fall: assert property (p_nc_fall) else $error("nonconform fell early");
    a_viol_hold: assert property (p_viol_hold) else $error("count moved");
    a_viol_floor: assert property (p_viol_floor) else $error("flag under floor");
    a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule : abrmon_top_props
bind abrmon_top abrmon_top_props #(.INTERVAL(INTERVAL)) u_abrmon_top_props (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .INTERVAL_END(INTERVAL_END),
    .BOUND_FLAGS(BOUND_FLAGS), .NONCONFORM(NONCONFORM), .VIOL_COUNT(VIOL_COUNT));
`default_nettype wire

/* tb/abrmon_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module abrmon_src_model #(
    parameter int NRM = 32
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        en,
    input wire logic        rm_all,
    input wire logic        bad,
    input wire logic [15:0] pacr,
    output logic            valid,
    output logic            clp,
    output logic            rm,
    output logic [15:0]     ccr,
    output logic [15:0]     mcr
);
    int n;
    always_ff @(posedge clk) begin
        if (rst) begin
            {valid, clp, rm, ccr, mcr} <= '0;
            n <= 0;
        end else if (!en) begin
            // Idle fields toggle so a stale value is never mistaken for a cell.
            {valid, rm} <= 2'b00;
            {clp, ccr, mcr} <= ~{clp, ccr, mcr};
        end else begin
            valid <= 1'b1;
            clp <= 1'b0;
            n <= (n == NRM - 1) ? 0 : n + 1;
            rm <= rm_all || n == NRM - 1;
            ccr <= bad ? pacr + 16'h0001 : pacr;
            mcr <= 16'h0010;
        end
    end
endmodule : abrmon_src_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import abrmon_pkg::*;
;
    logic clk = 0, rst = 1, ce = 1, en = 0, ra = 0, bd = 0, rx = 0, tx = 0;
    logic [15:0] nm = 16'h0010, pacr = 16'h0100, ccr, mcr;
    logic v, c, r, ie, nc;
    logic [4:0] fl;
    abrmon_cnt_t vc;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            finish_test();
        end
    end
    abrmon_top #(.INTERVAL(32'd100), .TRM(10)) u_abrmon_top (.CLK_SYS(clk), .RST(rst), .CE(ce),
        .FWD_VALID(v), .FWD_CLP(c), .FWD_RM(r), .FWD_CCR(ccr), .FWD_MCR(mcr), .PACR(pacr),
        .NEG_MCR(nm), .BWD_RX_RM(rx), .BWD_RX_CLP(1'b0), .BWD_TX_RM(tx), .BWD_TX_CLP(1'b0),
        .INTERVAL_END(ie), .BOUND_FLAGS(fl), .NONCONFORM(nc), .VIOL_COUNT(vc));
    abrmon_src_model u_abrmon_src_model (.clk(clk), .rst(rst), .en(en), .rm_all(ra), .bad(bd),
        .pacr(pacr), .valid(v), .clp(c), .rm(r), .ccr(ccr), .mcr(mcr));
    task chk(input string n, input abrmon_cnt_t e, input abrmon_cnt_t g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    task wait_end;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            #1;
            if (ie === 1'b1) return;
        end
        error_cnt++;
    endtask : wait_end
    // Three judgements: only the first may still hold cells of the previous mode.
    task run(input logic a, input logic b, input logic x, input logic t, input logic [15:0] m);
        @(posedge clk);
        {ra, bd, rx, tx, nm, en} <= {a, b, x, t, m, 1'b1};
        repeat (3) wait_end();
    endtask : run
    task t_conform;
        run(0, 0, 1, 0, 16'h0010);
        chk("flags", 0, fl);
        chk("viol", 0, vc);
    endtask : t_conform
    task t_fwd_high;
        run(1, 0, 0, 0, 16'h0010);
        chk("flags", 5'h02, fl);
        chk("nc", 1, nc);
    endtask : t_fwd_high
    task t_ccr_viol;
        run(1, 1, 0, 0, 16'h0010);
        chk("flags", 5'h12, fl);
        chk("viol", 100, vc);
    endtask : t_ccr_viol
    task t_mcr_viol; run(1, 0, 0, 0, 16'h000F); chk("viol", 100, vc); endtask
    task t_bwd_low; run(1, 0, 0, 1, 16'h0010); chk("flags", 5'h06, fl); endtask
    task t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        repeat (150) @(posedge clk);
        chk("frozen", 5'h06, fl);
        ce <= 1'b1;
    endtask : t_freeze
    task finish_test;
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_conform();
        t_fwd_high();
        t_ccr_viol();
        t_mcr_viol();
        t_bwd_low();
        t_freeze();
        t_conform();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
